// File: mps_pkg.sv
// Package of constants and types for the MII pin and strap block
package mps_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int NIBBLE_NS = 40;                               // 25 MHz nibble period
    localparam int NIBBLE_CYC = (NIBBLE_NS * CLK_MHZ) / 1000;    // Clock cycles per nibble
    localparam int HALF_CYC = NIBBLE_CYC / 2;
    localparam int STRAP_HOLD_NS = 100;                          // Strap settle time after reset release
    localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS * CLK_MHZ + 999) / 1000;

    // Register offsets on the plain port (byte addresses, one word each)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN = 8'h0c;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    localparam logic [7:0] REG_PHY_CTRL2 = 8'h14;
    localparam logic [7:0] REG_TX_COUNT = 8'h18;

    // Field positions
    localparam int CTRL_DUPLEX_BIT = 8;
    localparam int CTRL_ISOLATE_BIT = 10;
    localparam int CTRL2_IRQ_POL_BIT = 9;
    localparam int IRQ_RX_DONE_BIT = 0;
    localparam int IRQ_TX_DONE_BIT = 1;
    localparam int IRQ_RX_ERR_BIT = 2;
    localparam int IRQ_MDC_BIT = 3;
    localparam int IRQ_WIDTH = 4;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [IRQ_WIDTH-1:0] IRQ_EN_RESET = 4'h0;
    localparam logic [4:0] ADDR_DEFAULT = 5'h01;

    // Interface selector codes
    typedef enum logic [2:0] {
        MPS_IF_MII = 3'b000,
        MPS_IF_RMII = 3'b001,
        MPS_IF_SMII = 3'b010,
        MPS_IF_RSV3 = 3'b011,
        MPS_IF_MII_PRE = 3'b100,
        MPS_IF_RMII_B2B = 3'b101,
        MPS_IF_MII_B2B = 3'b110,
        MPS_IF_RSV7 = 3'b111
    } mps_iface_type;

    // Phases of the strap capture
    typedef enum logic [1:0] {
        MPS_ST_RESET = 2'b00,
        MPS_ST_SETTLE = 2'b01,
        MPS_ST_RUN = 2'b10
    } mps_phase_type;
endpackage : mps_pkg

// File: mps_sync.sv
`timescale 1ns/1ns
// Two flip-flop synchroniser for a group of single-bit inputs
module mps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // mps_sync

// File: mps_top.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// MII pin side of the transceiver: strap capture, nibble clocks, data and interrupt
// Function
// - Receive data lines 3, 2 and 1 are captured at reset as management address bits 0, 1 and 2.
// - Receive data line 0 is captured at reset as the duplex bit 8 of the control register.
// - The receive data valid pin is captured at reset as the top bit of the interface selector.
// - The receive error pin is captured at reset to enable or disable isolate mode.
// - The interrupt output is active low by default and active high when bit 9 of the second control register is set.
// - An interrupt enable and pending register set drives the interrupt output.
// - Management data moves on the edges of the management clock supplied by the controller.
// - In MII mode the device drives both the receive clock and the transmit clock.
// - The device drives receive data, valid and error, and takes transmit enable and transmit data.
// - The three-bit selector picks MII, RMII, SMII, preamble restore or a back-to-back mode; 011 and 111 are reserved.
// - The captured isolate strap loads bit 10 of the control register and defaults to disabled.
// - Management address bits 4 and 3 read zero and the default address is 00001.
module mps_top
    import mps_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Strap selector bits from the collision and carrier pins
    input wire logic [1:0] iface_select_low,
    // Receive pins, inputs during reset, driven once the straps are taken
    input wire logic [3:0] rxd_in,
    output logic [3:0] rxd_out,
    output logic [3:0] rxd_oe_n,
    input wire logic rx_dv_in,
    output logic rx_dv_out,
    output logic rx_dv_oe_n,
    input wire logic rx_er_in,
    output logic rx_er_out,
    output logic rx_er_oe_n,
    // Receive stream from the line side
    input wire logic [3:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic line_rx_error,
    // Nibble clocks to the MAC and transmit pins from it
    output logic rx_clk,
    output logic tx_clk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    // Transmit stream toward the line side
    output logic [3:0] line_tx_data,
    output logic line_tx_valid,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // Configuration seen by the rest of the device
    output logic [4:0] management_address,
    output logic [2:0] iface_mode,
    output logic isolate,
    output logic full_duplex_strap,
    // Interrupt
    output logic irq_out
);
    import mps_pkg::*;

    // Elaboration check: the divider toggles the nibble clock every half period,
    // so the period must be an even count of at least two cycles; a bad value
    // stops elaboration rather than giving a lopsided clock
    if (NIBBLE_CYC < 2 || (NIBBLE_CYC % 2) != 0) begin : g_bad_nibble
        $error("nibble period must be an even count of at least two cycles");
    end

    // Pin inputs through two flip-flops
    logic [3:0] rxd_s;
    logic rx_dv_s;
    logic rx_er_s;
    logic [1:0] sel_s;
    logic tx_en_s;
    logic [3:0] txd_s;
    logic mdc_s;
    logic mdio_s;

    mps_sync #(.WIDTH(15)) u_sync (
        .clock(clock),
        .rst(rst),
        .din({rxd_in, rx_dv_in, rx_er_in, iface_select_low, tx_en, txd, mdc, mdio_in}),
        .dout({rxd_s, rx_dv_s, rx_er_s, sel_s, tx_en_s, txd_s, mdc_s, mdio_s})
    );

    // Whole block state
    typedef struct packed {
        mps_phase_type phase;
        logic [7:0] settle;
        logic [7:0] div;
        logic nib_clk;
        logic [2:0] mgmt_addr_strap;
        logic [2:0] iface;
        logic [15:0] ctrl;
        logic [15:0] ctrl2;
        logic [IRQ_WIDTH-1:0] irq_stat;
        logic [IRQ_WIDTH-1:0] irq_en;
        logic [3:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic [3:0] tx_data;
        logic tx_valid;
        logic tx_en_d;
        logic rx_dv_d;
        logic mdc_d;
        logic mdio_q;
        logic [15:0] tx_count;
        logic [31:0] rdata;
    } mps_state_type;

    mps_state_type state;
    mps_state_type next_state;

    // Decoded sticky events for this cycle
    logic [IRQ_WIDTH-1:0] events;
    logic nib_rise;
    logic pins_out;

    // Pack the strap address with bits 4 and 3 held low
    function automatic logic [4:0] full_addr(input logic [2:0] low);
        full_addr = {2'b00, low};
    endfunction

    assign nib_rise = (state.div == 8'(HALF_CYC - 1)) && !state.nib_clk;
    assign pins_out = (state.phase == MPS_ST_RUN);

    // Next-state logic
    always_comb begin
        next_state = state;
        events = '0;
        next_state.rdata = 32'h0000_0000;
        // Strap capture: sample pins only while reset influence lasts
        case (state.phase)
            MPS_ST_RESET: begin
                next_state.phase = MPS_ST_SETTLE;
                next_state.settle = '0;
            end
            MPS_ST_SETTLE: begin
                next_state.settle = state.settle + 8'h01;
                if (state.settle == 8'(STRAP_HOLD_CYC)) begin
                    next_state.phase = MPS_ST_RUN;
                    next_state.mgmt_addr_strap = {rxd_s[1], rxd_s[2], rxd_s[3]};
                    next_state.ctrl[CTRL_DUPLEX_BIT] = rxd_s[0];
                    next_state.iface = {rx_dv_s, sel_s};
                    next_state.ctrl[CTRL_ISOLATE_BIT] = rx_er_s;
                end
            end
            MPS_ST_RUN: begin
                next_state.phase = MPS_ST_RUN;
            end
            default: begin
                next_state.phase = MPS_ST_RESET;
            end
        endcase

        // Nibble clock divider from the system clock
        if (state.div == 8'(HALF_CYC - 1)) begin
            next_state.div = '0;
            next_state.nib_clk = !state.nib_clk;
        end else begin
            next_state.div = state.div + 8'h01;
        end

        // Receive and transmit nibble transfer on the rising nibble edge
        if (nib_rise && pins_out) begin
            next_state.rxd = line_rx_data;
            next_state.rx_dv = line_rx_valid;
            next_state.rx_er = line_rx_error;
            next_state.tx_data = txd_s;
            next_state.tx_valid = tx_en_s && !state.ctrl[CTRL_ISOLATE_BIT];
            next_state.tx_en_d = tx_en_s;
            next_state.rx_dv_d = line_rx_valid;
            if (tx_en_s && !state.tx_en_d) begin
                next_state.tx_count = state.tx_count + 16'h0001;
            end
            if (!tx_en_s && state.tx_en_d) begin
                events[IRQ_TX_DONE_BIT] = 1'b1;
            end
            if (!line_rx_valid && state.rx_dv_d) begin
                events[IRQ_RX_DONE_BIT] = 1'b1;
            end
            if (line_rx_error) begin
                events[IRQ_RX_ERR_BIT] = 1'b1;
            end
        end

        // Management clock edges; data captured on the rising edge
        next_state.mdc_d = mdc_s;
        if (mdc_s && !state.mdc_d) begin
            next_state.mdio_q = mdio_s;
            events[IRQ_MDC_BIT] = 1'b1;
        end

        // Register writes
        if (reg_write) begin
            case (reg_addr)
                REG_CTRL: next_state.ctrl = reg_wdata[15:0];
                REG_IRQ_EN: next_state.irq_en = reg_wdata[IRQ_WIDTH-1:0];
                REG_IRQ_CLR: next_state.irq_stat = state.irq_stat & ~reg_wdata[IRQ_WIDTH-1:0];
                REG_PHY_CTRL2: next_state.ctrl2 = reg_wdata[15:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_state.irq_stat = next_state.irq_stat | events;

        // Register reads, answered one cycle later
        if (reg_read) begin
            case (reg_addr)
                REG_CTRL: next_state.rdata = {16'h0000, state.ctrl};
                REG_ADDR: next_state.rdata = {27'h0, full_addr(state.mgmt_addr_strap)};
                REG_IRQ_STAT: next_state.rdata = {28'h0, state.irq_stat};
                REG_IRQ_EN: next_state.rdata = {28'h0, state.irq_en};
                REG_PHY_CTRL2: next_state.rdata = {16'h0000, state.ctrl2};
                REG_TX_COUNT: next_state.rdata = {16'h0000, state.tx_count};
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state.phase <= MPS_ST_RESET;
            state.settle <= '0;
            state.div <= '0;
            state.nib_clk <= 1'b0;
            state.mgmt_addr_strap <= ADDR_DEFAULT[2:0];
            state.iface <= MPS_IF_MII;
            state.ctrl <= CTRL_RESET;
            state.ctrl2 <= CTRL2_RESET;
            state.irq_stat <= '0;
            state.irq_en <= IRQ_EN_RESET;
            state.rxd <= '0;
            state.rx_dv <= 1'b0;
            state.rx_er <= 1'b0;
            state.tx_data <= '0;
            state.tx_valid <= 1'b0;
            state.tx_en_d <= 1'b0;
            state.rx_dv_d <= 1'b0;
            state.mdc_d <= 1'b0;
            state.mdio_q <= 1'b0;
            state.tx_count <= '0;
            state.rdata <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Pin drive: receive pins stay inputs until straps are taken
    assign rxd_oe_n = pins_out ? 4'h0 : 4'hf;
    assign rx_dv_oe_n = !pins_out;
    assign rx_er_oe_n = !pins_out;
    assign rxd_out = state.rxd;
    assign rx_dv_out = state.rx_dv;
    assign rx_er_out = state.rx_er;
    assign rx_clk = state.nib_clk;
    assign tx_clk = state.nib_clk;
    assign line_tx_data = state.tx_data;
    assign line_tx_valid = state.tx_valid;

    // Management data is read-only here; the frame engine lives elsewhere
    assign mdio_out = state.mdio_q;
    assign mdio_oe_n = 1'b1;

    // Configuration outputs
    assign management_address = full_addr(state.mgmt_addr_strap);
    assign iface_mode = state.iface;
    assign isolate = state.ctrl[CTRL_ISOLATE_BIT];
    assign full_duplex_strap = state.ctrl[CTRL_DUPLEX_BIT];
    assign reg_rdata = state.rdata;

    // Interrupt level with programmable polarity
    assign irq_out = (|(state.irq_stat & state.irq_en)) ^ !state.ctrl2[CTRL2_IRQ_POL_BIT];

    // Assertions
    sequence s_settle_done;
        state.phase == MPS_ST_SETTLE && state.settle == 8'(STRAP_HOLD_CYC);
    endsequence

    property p_addr_strap;
        @(posedge clock) disable iff (rst)
        s_settle_done |=> state.mgmt_addr_strap == {$past(rxd_s[1]), $past(rxd_s[2]), $past(rxd_s[3])};
    endproperty
    a_addr_strap: assert property (p_addr_strap) else $error("address strap mismatch");

    property p_duplex_strap;
        @(posedge clock) disable iff (rst)
        s_settle_done |=> full_duplex_strap == $past(rxd_s[0]);
    endproperty
    a_duplex_strap: assert property (p_duplex_strap) else $error("duplex strap mismatch");

    property p_iface_strap;
        @(posedge clock) disable iff (rst)
        s_settle_done |=> iface_mode[2] == $past(rx_dv_s);
    endproperty
    a_iface_strap: assert property (p_iface_strap) else $error("selector msb mismatch");

    property p_iso_strap;
        @(posedge clock) disable iff (rst)
        s_settle_done |=> isolate == $past(rx_er_s);
    endproperty
    a_iso_strap: assert property (p_iso_strap) else $error("isolate strap mismatch");

    property p_irq_pol;
        @(posedge clock) disable iff (rst)
        (state.irq_stat & state.irq_en) == '0 |-> irq_out == !state.ctrl2[CTRL2_IRQ_POL_BIT];
    endproperty
    a_irq_pol: assert property (p_irq_pol) else $error("idle interrupt level wrong");

    property p_irq_sticky;
        @(posedge clock) disable iff (rst)
        events[IRQ_TX_DONE_BIT] |=> state.irq_stat[IRQ_TX_DONE_BIT];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("event not latched");

    property p_clk_period;
        @(posedge clock) disable iff (rst)
        $rose(rx_clk) |-> ##(NIBBLE_CYC) $rose(rx_clk);
    endproperty
    a_clk_period: assert property (p_clk_period) else $error("nibble clock period wrong");

    property p_pins_hiz;
        @(posedge clock) disable iff (rst)
        state.phase != MPS_ST_RUN |-> rxd_oe_n == 4'hf && rx_dv_oe_n && rx_er_oe_n;
    endproperty
    a_pins_hiz: assert property (p_pins_hiz) else $error("strap pins driven early");

    property p_addr_high;
        @(posedge clock) disable iff (rst)
        management_address[4:3] == 2'b00;
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("address high bits set");
endmodule // mps_top

// File: mps_mac_model.sv
// MAC and station manager model facing the MII pins of the transceiver
`timescale 1ns/1ns
module mps_mac_model (
    // Board straps and the transceiver's receive pin drivers
    input wire logic [5:0] strap_level,
    input wire logic [5:0] dut_out,
    input wire logic [5:0] dut_oe_n,
    output logic [5:0] pin_level,
    // Transmit side, timed by the clock the transceiver gives
    input wire logic tx_clk,
    input wire logic tx_go,
    input wire logic [3:0] tx_nib,
    output logic tx_en,
    output logic [3:0] txd,
    // Management side
    input wire logic mdc_run,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    output logic mdc,
    output logic mdio_in
);
    logic mdio_bit = 1'b0;

    // A pin shows its strap resistor until the transceiver turns its driver on
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            pin_level[k] = dut_oe_n[k] ? strap_level[k] : dut_out[k];
        end
    end

    // The MAC never drives either clock; it launches each nibble after a rise of the clock it is given
    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
    end
    always @(posedge tx_clk) begin
        tx_en <= tx_go;
        txd <= tx_go ? tx_nib : ~txd; // Idle nibble keeps changing so stale data never looks valid
    end

    // Management clock at 8 MHz only within a frame; it rests low between frames
    initial mdc = 1'b0;
    always begin
        #63 mdc = mdc_run;
        #62 mdc = 1'b0;
    end

    // Data launched on the falling edge so it is steady at the next rise
    always @(negedge mdc) begin
        mdio_bit <= ~mdio_bit;
    end

    // The line has a pull-up, so a released line reads high
    assign mdio_in = !mdio_oe_n ? mdio_out : (mdc_run ? mdio_bit : 1'b1);
endmodule // mps_mac_model

// File: tb_mps_top.sv
// Self-checking testbench for the MII pin and strap block
`timescale 1ns/1ns
module tb_mps_top;
    import mps_pkg::*;
    // Bench clock, reset and register port
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    // Pins, streams and model controls
    logic [1:0] iface_select_low = 2'h0;
    logic [5:0] strap_level = 6'h00;
    logic [5:0] pin_level;
    logic [3:0] rxd_out, rxd_oe_n, line_rx_data = 4'h0, line_tx_data, txd, tx_nib = 4'h0;
    logic rx_dv_out, rx_dv_oe_n, rx_er_out, rx_er_oe_n, line_rx_valid = 1'b0, line_rx_error = 1'b0;
    logic rx_clk, tx_clk, tx_en, line_tx_valid, mdc, mdio_in, mdio_out, mdio_oe_n, tx_go = 1'b0, mdc_run = 1'b0;
    logic [4:0] management_address;
    logic [2:0] iface_mode;
    logic isolate, irq_out, full_duplex_strap;
    logic rd_pend = 1'b0;
    // Bookkeeping
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic [31:0] seed = 32'd23;
    logic [31:0] r;
    logic [5:0] s;
    int miscompares = 0, compares = 0, cycles = 0, n_rx = 0, n_tx = 0;

    always #5 clock = ~clock; // Steady reference: the nibble rate is exactly a quarter of it

    mps_top dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .iface_select_low(iface_select_low), .rxd_in(pin_level[3:0]),
        .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .rx_dv_in(pin_level[4]), .rx_dv_out(rx_dv_out),
        .rx_dv_oe_n(rx_dv_oe_n), .rx_er_in(pin_level[5]), .rx_er_out(rx_er_out), .rx_er_oe_n(rx_er_oe_n),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid), .line_rx_error(line_rx_error),
        .rx_clk(rx_clk), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd), .line_tx_data(line_tx_data),
        .line_tx_valid(line_tx_valid), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .management_address(management_address), .iface_mode(iface_mode), .isolate(isolate),
        .full_duplex_strap(full_duplex_strap), .irq_out(irq_out));

    mps_mac_model mac (.strap_level(strap_level), .dut_out({rx_er_out, rx_dv_out, rxd_out}),
        .dut_oe_n({rx_er_oe_n, rx_dv_oe_n, rxd_oe_n}), .pin_level(pin_level), .tx_clk(tx_clk), .tx_go(tx_go),
        .tx_nib(tx_nib), .tx_en(tx_en), .txd(txd), .mdc_run(mdc_run), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));

    function logic [31:0] rand_word();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task stop_test();
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Comparison of a level seen on an output
    task check_pin(input string name, input logic [31:0] e, input logic [31:0] v);
        compares++;
        if (v !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, e, v);
        end
    endtask

    // Comparison of read data against the oldest note
    task check_reg(input logic [31:0] e, input logic [31:0] v);
        compares++;
        if (v !== e) begin
            miscompares++;
            $display("unexpected reg_rdata expected %h seen %h", e, v);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-way through that cycle
    always @(posedge clock) rd_pend <= reg_read;
    always @(negedge clock) begin
        if (rd_pend === 1'b1) begin
            check_reg(exp_q.pop_front(), reg_rdata & mask_q.pop_front());
        end
    end

    // Hang guard: the whole sequence needs under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            stop_test();
        end
    end

    always @(posedge rx_clk) n_rx++;
    always @(posedge tx_clk) n_tx++;

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // Straps: [3:0] receive data, [4] receive valid, [5] receive error
    task do_reset(input logic [5:0] st, input logic [1:0] sel);
        @(posedge clock);
        rst <= 1'b1;
        strap_level <= st;
        iface_select_low <= sel;
        wait_cyc(5);
        check_pin("addr_in_reset", 32'h01, management_address);
        check_pin("oe_n_in_reset", 32'h3f, {rx_er_oe_n, rx_dv_oe_n, rxd_oe_n});
        @(posedge clock);
        rst <= 1'b0;
        wait_cyc(30);
        check_pin("management_address", {2'b00, st[1], st[2], st[3]}, management_address);
        check_pin("iface_mode", {st[4], sel}, iface_mode);
        check_pin("isolate", st[5], isolate);
        check_pin("full_duplex_strap", st[0], full_duplex_strap);
        check_pin("oe_n_after", 32'h0, {rx_er_oe_n, rx_dv_oe_n, rxd_oe_n});
        reg_rd(REG_CTRL, {st[5], 1'b0, st[0], 8'h00}, 32'h500);
        reg_rd(REG_ADDR, {2'b00, st[1], st[2], st[3]}, 32'h1f);
    endtask

    task rx_err_pulse();
        @(posedge clock);
        line_rx_error <= 1'b1;
        wait_cyc(12);
        check_pin("rx_er_out", 32'h1, rx_er_out);
        @(posedge clock);
        line_rx_error <= 1'b0;
        wait_cyc(12);
    endtask

    initial begin
        // Every selector code, with random address and duplex straps; the last run leaves isolate off
        for (int i = 0; i < 8; i++) begin
            r = rand_word();
            s = {(i == 7) ? 1'b0 : r[5], i[2], r[3:0]};
            do_reset(s, i[1:0]);
            @(posedge clock);
            tx_nib <= r[11:8];
            tx_go <= 1'b1;
            wait_cyc(20);
            check_pin("line_tx_valid", !s[5], line_tx_valid);
            if (!s[5]) check_pin("line_tx_data", r[11:8], line_tx_data);
            @(posedge clock);
            tx_go <= 1'b0;
        end
        wait_cyc(20);
        reg_rd(REG_TX_COUNT, 32'h1, 32'hff);
        // Both nibble clocks at 25 MHz; count from mid-cycle so exactly 10 rising edges fall in the 40-cycle window
        @(negedge clock);
        n_rx = 0;
        n_tx = 0;
        wait_cyc(40);
        check_pin("rx_clk_rises", 32'd10, n_rx);
        check_pin("tx_clk_rises", 32'd10, n_tx);
        // Receive stream reaches the pins
        r = rand_word();
        @(posedge clock);
        line_rx_data <= r[3:0];
        line_rx_valid <= 1'b1;
        wait_cyc(12);
        check_pin("rxd_pins", {r[3:0]}, pin_level[3:0]);
        check_pin("rx_dv_out", 32'h1, rx_dv_out);
        reg_rd(8'hfc, 32'h0, 32'hffffffff);
        // Interrupt raised, polarity flipped, cleared, then masked
        reg_rd(REG_IRQ_EN, 32'h0, 32'hf);
        reg_wr(REG_IRQ_EN, 32'h4);
        reg_wr(REG_IRQ_CLR, 32'hf);
        rx_err_pulse();
        check_pin("irq_active_low", 32'h0, irq_out);
        reg_rd(REG_IRQ_STAT, 32'h4, 32'h4);
        reg_wr(REG_PHY_CTRL2, 32'h200);
        wait_cyc(3);
        check_pin("irq_active_high", 32'h1, irq_out);
        reg_wr(REG_IRQ_CLR, 32'h4);
        wait_cyc(3);
        check_pin("irq_cleared", 32'h0, irq_out);
        reg_rd(REG_IRQ_STAT, 32'h0, 32'h4);
        reg_wr(REG_PHY_CTRL2, 32'h0);
        reg_wr(REG_IRQ_EN, 32'h0);
        rx_err_pulse();
        check_pin("irq_masked", 32'h1, irq_out);
        reg_rd(REG_IRQ_STAT, 32'h4, 32'h4);
        // A management clock frame is seen by the device
        reg_wr(REG_IRQ_CLR, 32'h8);
        @(posedge clock);
        mdc_run <= 1'b1;
        wait_cyc(100);
        check_pin("mdio_oe_n", 32'h1, mdio_oe_n);
        @(posedge clock);
        mdc_run <= 1'b0;
        wait_cyc(20);
        // The model turns its data over once after the last rise, so the captured bit is the inverse
        check_pin("mdio_out", !mac.mdio_bit, mdio_out);
        reg_rd(REG_IRQ_STAT, 32'h8, 32'h8);
        wait_cyc(3);
        stop_test();
    end
endmodule // tb_mps_top
